/* File: hdl/secondary_clock_slot_id_regs.sv */
// slot id capability and secondary clock gating registers behind apb
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps

// Operation
// [R01] The slot capability identifier reads as 04h in bits 7:0 of the dword at A0h.
// [R02] The slot capability is off after reset and only turned on by eeprom-loaded configuration.
// [R03] Bits 15:8 of the dword at A0h read as B0h, linking to the express capability.
// [R04] Bits 20:16 hold a writable slot number and bit 21 a first-in-chassis flag, both reset to zero, with bits 23:22 reading zero.
// [R05] Bits 31:24 of the dword at A0h hold a writable chassis number that resets to zero.
// [R06] Each slot clock has a 2-bit field where codes 00, 01 and 10 run it and 11 stops it low, reset 00.
// [R07] Bits 8 to 12 each stop one device or bridge feedback clock low when set, running it when clear, reset 0.
// [R08] The output enable fields act only in forward bridge mode.
// [R09] Read-only bit 13 shows 1 while the secondary clock is stopped and 0 while it runs, reset 0.
// [R10] Writable bit 14 enables the clock-run protocol when set and resets to disabled.
// [R11] With mode bit 15 clear, the secondary clock stops only while the bridge is in D3hot.
// [R12] With mode bit 15 set, the secondary clock stops whenever the secondary bus is idle and no primary request waits.
// [R13] Clock stopping applies only while the protocol enable is set, and the clock restarts as soon as the stop condition ends.
// [R14] Writes to read-only and reserved bits are ignored and reserved bits read as zero.
module secondary_clock_slot_id_regs #(
    parameter int NUM_SLOT_CLOCKS = 4,
    parameter int NUM_DEV_CLOCKS  = 5
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    // eeprom configuration load
    input  wire logic                       eeprom_load_valid,
    input  wire logic                       eeprom_slot_id_enable,
    // bridge status
    input  wire logic                       forward_mode,
    input  wire logic                       d3hot_state,
    input  wire logic                       secondary_bus_idle,
    input  wire logic                       primary_request_pending,
    // clock gate enables and slot capability active flag
    output logic [NUM_SLOT_CLOCKS-1:0]      slot_clock_output_run,
    output logic [NUM_DEV_CLOCKS-1:0]       device_clock_output_run,
    output logic                            secondary_clock_output_run,
    output logic                            slot_id_active
);

    // the register layout has room for exactly these counts
    initial begin
        if (NUM_SLOT_CLOCKS != 4 || NUM_DEV_CLOCKS != 5) begin
            $error("clock counts must be 4 slots and 5 devices");
        end
    end

    slot_clock_pkg::clock_ctrl_t ctrl;
    slot_clock_pkg::slot_id_t    slot_id;
    logic                        clock_stopped;
    logic                        next_stop;
    logic                        setup_phase;
    logic                        access_done;
    logic                        hit_slot_cap;
    logic                        hit_clock_ctrl;
    logic                        wr_slot_cap;
    logic                        wr_clock_ctrl;
    logic [31:0]                 next_rdata;
    logic [31:0]                 slot_word;
    logic [31:0]                 ctrl_word;
    logic [31:0]                 merged_slot;
    logic [31:0]                 merged_ctrl;
    logic                        forward_meta;
    logic                        forward_sync;

    // a slot code runs its clock unless it is the stop code
    function automatic logic slot_code_runs(input logic [1:0] code);
        return code != slot_clock_pkg::SLOT_CODE_STOP;
    endfunction

    // byte lane merge for a partial write
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                                input logic [31:0] new_word,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // address decode and transfer phases
    assign setup_phase    = psel && !penable;
    assign access_done    = psel && penable && pready;
    assign hit_slot_cap   = paddr == slot_clock_pkg::SLOT_CAP_OFFSET;
    assign hit_clock_ctrl = paddr == slot_clock_pkg::CLOCK_CTRL_OFFSET;
    // [R02] writes dropped while inactive
    assign wr_slot_cap    = access_done && pwrite && hit_slot_cap && slot_id_active;
    assign wr_clock_ctrl  = access_done && pwrite && hit_clock_ctrl;

    // read word assembly
    always_comb begin
        next_rdata = slot_clock_pkg::READ_ZERO;
        if (hit_slot_cap && slot_id_active) begin
            // [R01] fixed slot_cap_identifier
            next_rdata[slot_clock_pkg::CAP_ID_LSB +: 8]   = slot_clock_pkg::SLOT_CAP_ID_VALUE;
            // [R03] fixed next link
            next_rdata[slot_clock_pkg::CAP_NEXT_LSB +: 8] = slot_clock_pkg::SLOT_CAP_NEXT_VALUE;
            // [R04] slot number and flag
            next_rdata[slot_clock_pkg::SLOT_NUM_LSB +: slot_clock_pkg::SLOT_NUM_W] =
                slot_id.slot_num;
            next_rdata[slot_clock_pkg::FIRST_CHASSIS_BIT] = slot_id.first_chassis;
            // [R05] chassis number
            next_rdata[slot_clock_pkg::CHASSIS_LSB +: slot_clock_pkg::CHASSIS_W] =
                slot_id.chassis;
        end else if (hit_clock_ctrl) begin
            next_rdata[slot_clock_pkg::SLOT_FIELD_LSB +: 8] = ctrl.slot_codes;
            next_rdata[slot_clock_pkg::DEV_FIELD_LSB +: 5]  = ctrl.dev_stops;
            // [R09] stop status readback
            next_rdata[slot_clock_pkg::STOP_STATUS_BIT]     = clock_stopped;
            next_rdata[slot_clock_pkg::CLKRUN_EN_BIT]       = ctrl.clkrun_en;
            next_rdata[slot_clock_pkg::CLKRUN_MODE_BIT]     = ctrl.clkrun_mode;
        end
    end

    // apb answer, one wait-free access phase
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            prdata  <= slot_clock_pkg::READ_ZERO;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            if (setup_phase) begin
                prdata  <= pwrite ? slot_clock_pkg::READ_ZERO : next_rdata;
                pslverr <= !(hit_slot_cap || hit_clock_ctrl);
            end
        end
    end

    // capability switched on by eeprom load only
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            // [R02] inactive after reset
            slot_id_active <= 1'b0;
        end else if (eeprom_load_valid) begin
            // [R02] eeprom turns it on
            slot_id_active <= eeprom_slot_id_enable;
        end
    end

    // current slot dword, writable fields only, as the base of a byte merge
    always_comb begin
        slot_word = slot_clock_pkg::READ_ZERO;
        slot_word[slot_clock_pkg::SLOT_NUM_LSB +: slot_clock_pkg::SLOT_NUM_W] =
            slot_id.slot_num;
        slot_word[slot_clock_pkg::FIRST_CHASSIS_BIT] = slot_id.first_chassis;
        slot_word[slot_clock_pkg::CHASSIS_LSB +: slot_clock_pkg::CHASSIS_W] =
            slot_id.chassis;
    end

    // current control dword, writable fields only
    // status bit 13 is left out so a merge never feeds it back
    always_comb begin
        ctrl_word = slot_clock_pkg::READ_ZERO;
        ctrl_word[slot_clock_pkg::SLOT_FIELD_LSB +: NUM_SLOT_CLOCKS * slot_clock_pkg::SLOT_FIELD_W] =
            ctrl.slot_codes;
        ctrl_word[slot_clock_pkg::DEV_FIELD_LSB +: NUM_DEV_CLOCKS] =
            ctrl.dev_stops;
        ctrl_word[slot_clock_pkg::CLKRUN_EN_BIT]   = ctrl.clkrun_en;
        ctrl_word[slot_clock_pkg::CLKRUN_MODE_BIT] = ctrl.clkrun_mode;
    end

    // byte lane merges for both writable dwords
    assign merged_slot = merge_bytes(slot_word, pwdata, pstrb);
    assign merged_ctrl = merge_bytes(ctrl_word, pwdata, pstrb);

    // slot identification writable fields
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            slot_id.slot_num      <= slot_clock_pkg::SLOT_NUM_RESET;
            slot_id.first_chassis <= 1'b0;
            slot_id.chassis       <= slot_clock_pkg::CHASSIS_RESET;
        end else if (wr_slot_cap) begin
            // [R04] slot number and flag written
            slot_id.slot_num      <=
                merged_slot[slot_clock_pkg::SLOT_NUM_LSB +: slot_clock_pkg::SLOT_NUM_W];
            slot_id.first_chassis <= merged_slot[slot_clock_pkg::FIRST_CHASSIS_BIT];
            // [R05] chassis written
            slot_id.chassis       <=
                merged_slot[slot_clock_pkg::CHASSIS_LSB +: slot_clock_pkg::CHASSIS_W];
            // [R14] bits 23:22 have no storage
        end
    end

    // software clock control fields
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            // [R06] slot codes reset to run
            ctrl.slot_codes  <= {NUM_SLOT_CLOCKS{slot_clock_pkg::SLOT_CODE_RESET}};
            // [R07] device bits reset to run
            ctrl.dev_stops   <= {NUM_DEV_CLOCKS{slot_clock_pkg::DEV_BIT_RESET}};
            // [R10] protocol off after reset
            ctrl.clkrun_en   <= 1'b0;
            ctrl.clkrun_mode <= 1'b0;
        end else if (wr_clock_ctrl) begin
            // [R06] slot codes written
            ctrl.slot_codes  <= merged_ctrl[slot_clock_pkg::SLOT_FIELD_LSB +:
                                            NUM_SLOT_CLOCKS * slot_clock_pkg::SLOT_FIELD_W];
            // [R07] device stop bits written
            ctrl.dev_stops   <= merged_ctrl[slot_clock_pkg::DEV_FIELD_LSB +: NUM_DEV_CLOCKS];
            // [R10] protocol enable written
            ctrl.clkrun_en   <= merged_ctrl[slot_clock_pkg::CLKRUN_EN_BIT];
            ctrl.clkrun_mode <= merged_ctrl[slot_clock_pkg::CLKRUN_MODE_BIT];
            // [R14] status bit and upper half are not stored
        end
    end

    // bridge direction strap, two flops before use
    // only the second flop is read, the first may be metastable
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            forward_meta <= 1'b0;
            forward_sync <= 1'b0;
        end else begin
            forward_meta <= forward_mode;
            forward_sync <= forward_meta;
        end
    end

    // clock-run stop condition
    always_comb begin
        next_stop = 1'b0;
        // [R13] nothing stops while the protocol is off
        if (ctrl.clkrun_en) begin
            if (ctrl.clkrun_mode) begin
                // [R12] idle bus and nothing pending upstream
                next_stop = secondary_bus_idle && !primary_request_pending;
            end else begin
                // [R11] stop only in d3hot
                next_stop = d3hot_state;
            end
        end
    end

    // stop status and secondary clock gate, restart as soon as the condition ends
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            // [R09] status clear after reset
            clock_stopped              <= 1'b0;
            secondary_clock_output_run <= 1'b1;
        end else begin
            // [R13] follows the condition every cycle
            clock_stopped              <= next_stop;
            secondary_clock_output_run <= !next_stop;
        end
    end

    // slot clock gates
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            slot_clock_output_run <= {NUM_SLOT_CLOCKS{1'b1}};
        end else begin
            for (int s = 0; s < NUM_SLOT_CLOCKS; s++) begin
                // [R06] [R08] stop code acts in forward mode only
                slot_clock_output_run[s] <= !forward_sync ||
                    slot_code_runs(ctrl.slot_codes[s * slot_clock_pkg::SLOT_FIELD_W +:
                                                   slot_clock_pkg::SLOT_FIELD_W]);
            end
        end
    end

    // device and bridge feedback clock gates
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            device_clock_output_run <= {NUM_DEV_CLOCKS{1'b1}};
        end else begin
            for (int d = 0; d < NUM_DEV_CLOCKS; d++) begin
                // [R07] [R08] set bit stops it in forward mode only
                device_clock_output_run[d] <= !forward_sync || !ctrl.dev_stops[d];
            end
        end
    end

endmodule // secondary_clock_slot_id_regs

/* File: hdl/slot_clock_pkg.sv */
// constants and types for the slot id capability and secondary clock control
package slot_clock_pkg;

    // register byte offsets in configuration space
    localparam logic [7:0] SLOT_CAP_OFFSET     = 8'ha0;
    localparam logic [7:0] CLOCK_CTRL_OFFSET   = 8'ha4;

    // slot identification dword fields
    localparam logic [7:0] SLOT_CAP_ID_VALUE   = 8'h04;
    localparam logic [7:0] SLOT_CAP_NEXT_VALUE = 8'hb0;
    localparam int         CAP_ID_LSB          = 0;
    localparam int         CAP_NEXT_LSB        = 8;
    localparam int         SLOT_NUM_LSB        = 16;
    localparam int         SLOT_NUM_W          = 5;
    localparam int         FIRST_CHASSIS_BIT   = 21;
    localparam int         CHASSIS_LSB         = 24;
    localparam int         CHASSIS_W           = 8;
    localparam logic [4:0] SLOT_NUM_RESET      = 5'h00;
    localparam logic [7:0] CHASSIS_RESET       = 8'h00;

    // clock control dword fields
    localparam int         SLOT_FIELD_W        = 2;
    localparam int         SLOT_FIELD_LSB      = 0;
    localparam int         DEV_FIELD_LSB       = 8;
    localparam int         STOP_STATUS_BIT     = 13;
    localparam int         CLKRUN_EN_BIT       = 14;
    localparam int         CLKRUN_MODE_BIT     = 15;
    localparam logic [1:0] SLOT_CODE_STOP      = 2'h3;
    localparam logic [1:0] SLOT_CODE_RESET     = 2'h0;
    localparam logic       DEV_BIT_RESET       = 1'h0;

    // apb answer values
    localparam logic [31:0] READ_ZERO          = 32'h0000_0000;

    // software controlled clock gating state
    typedef struct packed {
        logic [7:0] slot_codes;   // four 2-bit slot fields
        logic [4:0] dev_stops;    // device 1..4 and bridge feedback
        logic       clkrun_en;
        logic       clkrun_mode;
    } clock_ctrl_t;

    // slot identification state
    typedef struct packed {
        logic [4:0] slot_num;
        logic       first_chassis;
        logic [7:0] chassis;
    } slot_id_t;

endpackage

/* File: dv/secondary_clock_slot_id_regs_chk.sv */
// assertions on the slot id and clock gating register block
`timescale 1ns/1ps
module secondary_clock_slot_id_regs_chk #(
    parameter int NUM_SLOT_CLOCKS = 4,
    parameter int NUM_DEV_CLOCKS  = 5
) (
    input wire logic                       core_clk,
    input wire logic                       rst_b,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic                       pready,
    input wire logic [7:0]                 paddr,
    input wire logic [31:0]                prdata,
    input wire logic                       forward_mode,
    input wire logic                       d3hot_state,
    input wire logic [NUM_SLOT_CLOCKS-1:0] slot_clock_output_run,
    input wire logic                       secondary_clock_output_run,
    input wire logic                       slot_id_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // completed reads of each dword
    sequence rd_cap;
        psel && penable && pready && !pwrite && paddr == 8'ha0 && slot_id_active;
    endsequence
    sequence rd_cap_hidden;
        psel && penable && pready && !pwrite && paddr == 8'ha0 && !slot_id_active;
    endsequence
    sequence rd_ctl;
        psel && penable && pready && !pwrite && paddr == 8'ha4;
    endsequence
    chk_cap_header: assert property (
        rd_cap |-> prdata[15:0] == 16'hb004) else $error("capability header wrong");
    chk_cap_hidden: assert property (
        rd_cap_hidden |-> prdata == 32'h0) else $error("inactive capability visible");
    chk_slot_rsvd: assert property (
        rd_cap |-> prdata[23:22] == 2'h0) else $error("slot reserved bits set");
    chk_ctl_rsvd: assert property (
        rd_ctl |-> prdata[31:16] == 16'h0) else $error("control reserved bits set");
    chk_stop_status: assert property (
        rd_ctl |-> prdata[13] == !secondary_clock_output_run) else $error("stop status wrong");
    chk_clkrun_off: assert property (
        rd_ctl ##0 !prdata[14] |-> secondary_clock_output_run) else $error("stopped while off");
    chk_mode0_run: assert property (
        rd_ctl ##0 (prdata[15:14] == 2'h1 && !d3hot_state && !$past(d3hot_state))
        |-> secondary_clock_output_run) else $error("stopped outside d3hot");
    chk_slot_code: assert property (
        rd_ctl ##0 (forward_mode && prdata[1:0] == 2'h3) |-> !slot_clock_output_run[0])
        else $error("slot code 3 not stopping");
    chk_reset_idle: assert property (
        $rose(rst_b) |-> !slot_id_active && secondary_clock_output_run
        && (&slot_clock_output_run)) else $error("reset outputs wrong");
endmodule // secondary_clock_slot_id_regs_chk

/* File: dv/slot_bus_partner.sv */
// secondary bus activity model feeding the clock-run idle condition
`timescale 1ns/1ps
module slot_bus_partner (
    input wire logic core_clk,
    input wire logic busy_req,
    output logic     secondary_bus_idle
);
    // idle follows the bus activity one edge late
    always_ff @(posedge core_clk) begin
        secondary_bus_idle <= !busy_req;
    end
endmodule // slot_bus_partner

/* File: dv/secondary_clock_slot_id_regs_tb_top.sv */
// self-checking bench for the slot id and clock gating registers
`timescale 1ns/1ps
module secondary_clock_slot_id_regs_tb_top;
    logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr, busy_req, se;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, wd, a4;
    logic [3:0]  slot_run;
    logic [4:0]  dev_run;
    logic        sec_run, slot_id_active, eeprom_load_valid, eeprom_slot_id_enable;
    logic        forward_mode, d3hot_state, secondary_bus_idle, primary_request_pending;
    int          err_count, samples_checked, seed, i;
    // bench clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    secondary_clock_slot_id_regs i_secondary_clock_slot_id_regs (.core_clk(core_clk),
        .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .eeprom_load_valid(eeprom_load_valid), .eeprom_slot_id_enable(eeprom_slot_id_enable),
        .forward_mode(forward_mode), .d3hot_state(d3hot_state),
        .secondary_bus_idle(secondary_bus_idle), .primary_request_pending(primary_request_pending),
        .slot_clock_output_run(slot_run), .device_clock_output_run(dev_run),
        .secondary_clock_output_run(sec_run), .slot_id_active(slot_id_active));
    slot_bus_partner i_slot_bus_partner (.core_clk(core_clk), .busy_req(busy_req),
        .secondary_bus_idle(secondary_bus_idle));
    // apb master: hold the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        {pwrite, paddr, pwdata} <= {w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q  = prdata;
        se = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // model of the gate enables and stop status
    task automatic outs;
        logic stop;
        stop = a4[14] && (a4[15] ? (!busy_req && !primary_request_pending) : d3hot_state);
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        for (i = 0; i < 4; i++) chk("slot run", !forward_mode || a4[2*i+:2] != 2'h3, slot_run[i]);
        for (i = 0; i < 5; i++) chk("dev run", !forward_mode || !a4[8+i], dev_run[i]);
        chk("sec run", !stop, sec_run);
        apb(1'b0, 8'ha4, 32'h0);
        chk("ctl read", a4 | {18'h0, stop, 13'h0}, q);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        $display("[FAIL] watchdog exp done got hang");
        conclude;
    end
    initial begin
        seed = 19;
        {rst_b, psel, penable, pwrite, paddr, pwdata, a4} = '0;
        {eeprom_load_valid, eeprom_slot_id_enable, d3hot_state, primary_request_pending} = '0;
        {forward_mode, busy_req} = 2'h3;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        chk("slot id off", 32'h0, slot_id_active);
        apb(1'b0, 8'ha0, 32'h0);
        chk("cap hidden", 32'h0, q);
        @(posedge core_clk);
        {eeprom_slot_id_enable, eeprom_load_valid} <= 2'h3;
        @(posedge core_clk);
        eeprom_load_valid <= 1'b0;
        repeat (2) @(negedge core_clk);
        chk("slot id on", 32'h1, slot_id_active);
        apb(1'b0, 8'ha0, 32'h0);
        chk("cap reset", 32'h0000b004, q);
        outs;
        wd = $random(seed);
        apb(1'b1, 8'ha0, wd);
        apb(1'b0, 8'ha0, 32'h0);
        chk("cap rw", (wd & 32'hff3f0000) | 32'h0000b004, q);
        apb(1'b0, 8'ha8, 32'h0);
        chk("unmapped", 32'h0, q);
        chk("unmapped err", 32'h1, se);
        $display("slot id test done");
        for (int k = 0; k < 8; k++) begin
            wd = ($random(seed) & 32'hffff3f00) | {4{k[1:0]}};
            forward_mode <= k[2];
            apb(1'b1, 8'ha4, wd);
            a4 = wd & 32'h0000dfff;
            outs;
        end
        for (int k = 0; k < 17; k++) begin
            {d3hot_state, busy_req, primary_request_pending} <= (k < 16) ? k[2:0] : 3'h4;
            a4 = (k < 16) ? {16'h0, k[3], 15'h4000} : 32'h00008000;
            apb(1'b1, 8'ha4, a4);
            outs;
        end
        $display("clock gating test done");
        conclude;
    end
endmodule // secondary_clock_slot_id_regs_tb_top
bind secondary_clock_slot_id_regs secondary_clock_slot_id_regs_chk #(
    .NUM_SLOT_CLOCKS(NUM_SLOT_CLOCKS), .NUM_DEV_CLOCKS(NUM_DEV_CLOCKS)) i_chk (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .paddr(paddr), .prdata(prdata), .forward_mode(forward_mode),
    .d3hot_state(d3hot_state), .slot_clock_output_run(slot_clock_output_run),
    .secondary_clock_output_run(secondary_clock_output_run), .slot_id_active(slot_id_active));
